/* inc/emtc_pkg.sv */
package emtc_pkg;
    // Register byte offsets
    localparam logic [7:0] ADR_CFG  = 8'h00;
    localparam logic [7:0] ADR_DIV  = 8'h04;
    localparam logic [7:0] ADR_STAT = 8'h08;

    // Field positions
    localparam int UNDIV_BIT    = 0;
    localparam int OSC_BIT      = 1;
    localparam int PSEL_LSB     = 4;
    localparam int STAT_SRC_LSB = 1;
    localparam int STAT_PIN_LSB = 8;

    // Values after reset
    localparam logic [3:0] PSEL_RST_COMPAT = 4'h5;
    localparam logic [3:0] PSEL_RST_FAST   = 4'h0;
    localparam logic [7:0] DIV_RST         = 8'h01;

    // Cycle counts
    localparam logic [1:0] FETCH_COMPAT   = 2'h3;
    localparam logic [4:0] MC_CLOCKS      = 5'h06;
    localparam logic [2:0] LEN_MAX_FAST   = 3'h5;
    localparam logic [2:0] LEN_MAX_COMPAT = 3'h4;

    // Oscillator source codes
    localparam logic [1:0] SRC_XTAL = 2'h0;
    localparam logic [1:0] SRC_EXT  = 2'h1;
    localparam logic [1:0] SRC_RC   = 2'h2;

    // Instruction timer states
    typedef enum logic {INS_IDLE, INS_RUN} emtc_ins_e;
endpackage

/* rtl/emtc_prescaler.sv */
`timescale 1ns/1ps
module emtc_prescaler #(
    parameter int PSC_W = 4,
    parameter int PINS  = 6
) (
    // Clock and reset
    input  wire logic             clock,
    input  wire logic             rst,
    // Control
    input  wire logic             sysClkEn,
    input  wire logic             fastMode,
    input  wire logic [PSC_W-1:0] preSel,
    input  wire logic             twoBypass,
    // Pins
    input  wire logic [PINS-1:0]  pinIn,
    // Results
    output logic                  timerTick,
    output logic                  timerTwoTick,
    output logic [PINS-1:0]       pinSampled
);
    if (PSC_W != 4) $error("prescaler select must be four bits");
    if (PINS < 1) $error("need at least one sampled pin");

    typedef struct packed {
        logic [PSC_W-1:0] cnt;
        logic             tick;
        logic             twoTick;
        logic [PINS-1:0]  smp;
    } emtc_psc_s;

    emtc_psc_s r;
    emtc_psc_s n;
    logic      wrap;

    // Divide by select plus one, sample pins
    always_comb begin
        n = r;
        wrap = sysClkEn && (r.cnt >= preSel);    // [RL8]
        if (sysClkEn) begin
            n.cnt = wrap ? '0 : r.cnt + 1'b1;
        end
        n.tick = wrap;
        n.twoTick = twoBypass ? sysClkEn : wrap; // [RL10]
        if (fastMode ? sysClkEn : wrap) begin
            n.smp = pinIn;                       // [RL11]
        end
        if (rst) begin
            n = '0;
        end
    end

    // State register
    always_ff @(posedge clock) begin
        r <= n;
    end

    assign timerTick    = r.tick;
    assign timerTwoTick = r.twoTick;
    assign pinSampled   = r.smp;

    AST_SMP_FAST: assert property (@(posedge clock) disable iff (rst) // [RL11]
        fastMode && sysClkEn |=> pinSampled == $past(pinIn))
        else $error("pins not sampled on system clock in fast mode");
    AST_T2_BYPASS: assert property (@(posedge clock) disable iff (rst) // [RL10]
        twoBypass && sysClkEn |=> timerTwoTick)
        else $error("timer two tick missing while bypassing prescaler");
    AST_PSC_GAP: assert property (@(posedge clock) disable iff (rst) // [RL8]
        timerTick && preSel != '0 && $stable(preSel) |=> !timerTick)
        else $error("prescaler ticked faster than selected");
endmodule

/* rtl/emtc_top.sv */
`timescale 1ns/1ps
// Function
// (RL1) Fetch strobe every three system clocks in compat mode, every clock in fast.
// (RL2) Instruction lasts 6/12/18/24 clocks in compat mode, 1 to 5 in fast.
// (RL3) Fast mode when compatibility fuse disabled, compat mode when enabled.
// (RL4) After reset, clock divides by two in compat mode, by one in fast; the code divides by one in compat mode too when undivFuseEn is set.
// (RL5) Undivided mode drops the divide-by-two; divider may slow the clock further.
// (RL6) Clock source is crystal, external clock or internal RC oscillator.
// (RL7) Undivided mode and divider apply to the second source likewise.
// (RL8) One four-bit prescaler feeds timers and watchdog, rate clock to clock/16.
// (RL9) Prescaler select resets to 5 in compat mode, 0 in fast.
// (RL10) Prescaler does not affect timer two in clock-out or baud mode.
// (RL11) Timer and interrupt pins sampled at prescaler rate compat, every clock fast.
// (RL12) Reset pin active high when polarity select high, else active low.
// (RL13) External reset held 12 clocks compat mode, 2 clocks fast.
// (RL14) Power-on reset resets the device with no reset pin activity.
// (RL15) Prescaler select sits in config bits 7..4, writable, restored by reset.
// (RL16) Mode and clock defaults latched at reset, held until next reset.
module emtc_top #(
    parameter int DIV_W = 8
) (
    // Clock and power-on reset
    input  wire logic       clock,
    input  wire logic       rst,
    // Wishbone slave
    input  wire logic       cyc_i,
    input  wire logic       stb_i,
    input  wire logic       we_i,
    input  wire logic [7:0] adr_i,
    input  wire logic [3:0] sel_i,
    input  wire logic [31:0] dat_i,
    output logic [31:0]     dat_o,
    output logic            ack_o,
    // Nonvolatile configuration
    input  wire logic       compatFuseEn,
    input  wire logic       undivFuseEn,
    input  wire logic       oscSelFuse,
    input  wire logic [1:0] srcAFuse,
    input  wire logic [1:0] srcBFuse,
    // Reset pin
    input  wire logic       resetPin,
    input  wire logic       resetPolaritySelect,
    // Oscillator ticks, indexed by source code
    input  wire logic [2:0] oscATick,
    input  wire logic [2:0] oscBTick,
    // CPU instruction timing
    input  wire logic       instrStart,
    input  wire logic [2:0] instrLen,
    // Timer two modes
    input  wire logic       timerTwoClockOutMode,
    input  wire logic       timerTwoBaudMode,
    // External pins
    input  wire logic       timerZeroInput,
    input  wire logic       timerOneInput,
    input  wire logic       timerTwoInput,
    input  wire logic       timerTwoExternalTrigger,
    input  wire logic       externalInterruptZero,
    input  wire logic       externalInterruptOne,
    // Results
    output logic            coreReset,
    output logic            fastMode,
    output logic            sysClkEn,
    output logic            fetchEn,
    output logic            instrDone,
    output logic            timerTick,
    output logic            timerTwoTick,
    output logic [5:0]      sampledPins
);
    if (DIV_W < 2 || DIV_W > 8) $error("divider width must be 2 to 8");

    typedef struct packed {
        logic                  fast;
        logic [1:0]            srcA;
        logic [1:0]            srcB;
        logic                  undiv;
        logic                  second_oscillator_source;
        logic [3:0]            preSel;
        logic [DIV_W-1:0]      div;
        logic [DIV_W+1:0]      divCnt;
        logic                  sysEn;
        logic [1:0]            fetchCnt;
        logic                  fetchEn;
        emtc_pkg::emtc_ins_e   ins;
        logic [4:0]            insCnt;
        logic [4:0]            insTgt;
        logic                  insDone;
        logic                  ack;
        logic [31:0]           dat;
        logic                  coreRst;
    } emtc_top_s;

    emtc_top_s        r;
    emtc_top_s        n;
    logic             pinAct;
    logic             anyRst;
    logic             oscTick;
    logic [1:0]       srcCur;
    logic [31:0]      rd;
    logic [5:0]       smpPins;

    // Last count of the oscillator divider; zero divides by 2^DIV_W
    function automatic logic [DIV_W+1:0] divLimit(input logic undiv,
                                                  input logic [DIV_W-1:0] d);
        logic [DIV_W+1:0] v;
        v = (d == '0) ? ((DIV_W+2)'(1) << DIV_W) : {2'h0, d};
        if (!undiv) begin
            v = v << 1;                          // [RL5]
        end
        return v - (DIV_W+2)'(1);
    endfunction

    // Tick of one oscillator set; unknown codes fall back to crystal
    function automatic logic pickTick(input logic [1:0] s,
                                      input logic [2:0] t);
        return (s > emtc_pkg::SRC_RC) ? t[emtc_pkg::SRC_XTAL] : t[s];
    endfunction

    // Instruction length in system clocks
    function automatic logic [4:0] insClocks(input logic f,
                                             input logic [2:0] len);
        logic [2:0] l;
        logic [4:0] e;
        l = (len == 3'h0) ? 3'h1 : len;
        if (f && l > emtc_pkg::LEN_MAX_FAST) begin
            l = emtc_pkg::LEN_MAX_FAST;
        end
        if (!f && l > emtc_pkg::LEN_MAX_COMPAT) begin
            l = emtc_pkg::LEN_MAX_COMPAT;
        end
        e = {2'h0, l};
        return f ? e : 5'(e * emtc_pkg::MC_CLOCKS);  // [RL2]
    endfunction

    // Reset sources
    assign pinAct = resetPolaritySelect ? resetPin : ~resetPin;  // [RL12]
    assign anyRst = rst | pinAct;                                // [RL14]

    // Selected oscillator source
    assign srcCur  = r.second_oscillator_source ? r.srcB : r.srcA;
    assign oscTick = r.second_oscillator_source ? pickTick(r.srcB, oscBTick)          // [RL7]
                            : pickTick(r.srcA, oscATick);        // [RL6]

    // Register read data
    always_comb begin
        rd = '0;
        case (adr_i)
            emtc_pkg::ADR_CFG: begin
                rd[emtc_pkg::PSEL_LSB +: 4] = r.preSel;
                rd[emtc_pkg::OSC_BIT]       = r.second_oscillator_source;
                rd[emtc_pkg::UNDIV_BIT]     = r.undiv;
            end
            emtc_pkg::ADR_DIV: begin
                rd[DIV_W-1:0] = r.div;
            end
            emtc_pkg::ADR_STAT: begin
                rd[0] = r.fast;
                rd[emtc_pkg::STAT_SRC_LSB +: 2] = srcCur;
                rd[emtc_pkg::STAT_PIN_LSB +: 6] = smpPins;
            end
            default: begin
                rd = '0;
            end
        endcase
    end

    // Next state
    always_comb begin
        n = r;
        n.sysEn   = 1'b0;
        n.fetchEn = 1'b0;
        n.insDone = 1'b0;
        n.ack     = 1'b0;
        n.coreRst = anyRst;

        // Oscillator divider produces the system clock enable
        if (oscTick) begin
            if (r.divCnt >= divLimit(r.undiv, r.div)) begin  // [RL5]
                n.divCnt = '0;
                n.sysEn  = 1'b1;
            end else begin
                n.divCnt = r.divCnt + 1'b1;
            end
        end

        // Code fetch strobe
        if (r.sysEn) begin
            if (r.fast || r.fetchCnt == emtc_pkg::FETCH_COMPAT - 2'h1) begin
                n.fetchEn  = 1'b1;                          // [RL1]
                n.fetchCnt = 2'h0;
            end else begin
                n.fetchCnt = r.fetchCnt + 2'h1;
            end
        end

        // Instruction duration timer
        case (r.ins)
            emtc_pkg::INS_IDLE: begin
                if (instrStart) begin
                    n.ins    = emtc_pkg::INS_RUN;
                    n.insCnt = 5'h00;
                    n.insTgt = insClocks(r.fast, instrLen);  // [RL2]
                end
            end
            emtc_pkg::INS_RUN: begin
                if (r.sysEn) begin
                    n.insCnt = r.insCnt + 5'h01;
                    if (n.insCnt == r.insTgt) begin
                        n.insDone = 1'b1;
                        n.ins     = emtc_pkg::INS_IDLE;
                    end
                end
            end
            default: begin
                n.ins = emtc_pkg::INS_IDLE;
            end
        endcase

        // Wishbone access, one wait cycle, unmapped reads zero
        if (cyc_i && stb_i && !r.ack) begin
            n.ack = 1'b1;
            n.dat = rd;
            if (we_i && sel_i[0]) begin
                case (adr_i)
                    emtc_pkg::ADR_CFG: begin
                        n.preSel = dat_i[emtc_pkg::PSEL_LSB +: 4];  // [RL15]
                        n.second_oscillator_source   = dat_i[emtc_pkg::OSC_BIT];
                        n.undiv  = dat_i[emtc_pkg::UNDIV_BIT];      // [RL5]
                    end
                    emtc_pkg::ADR_DIV: begin
                        n.div = dat_i[DIV_W-1:0];
                    end
                    default: begin
                        n.dat = rd;
                    end
                endcase
            end
        end

        // Any reset reloads mode and clock defaults from the fuses, the divider from DIV_RST
        if (anyRst) begin
            n         = '0;
            n.coreRst = 1'b1;
            n.fast    = !compatFuseEn;                      // [RL3] [RL16]
            n.srcA    = srcAFuse;
            n.srcB    = srcBFuse;
            n.second_oscillator_source    = oscSelFuse;
            n.undiv   = compatFuseEn ? undivFuseEn : 1'b1;  // [RL4]
            n.div     = DIV_W'(emtc_pkg::DIV_RST);
            n.preSel  = compatFuseEn ? emtc_pkg::PSEL_RST_COMPAT
                                     : emtc_pkg::PSEL_RST_FAST;  // [RL9] [RL15]
        end
    end

    // State register
    always_ff @(posedge clock) begin
        r <= n;
    end

    // Prescaler and pin sampling
    emtc_prescaler #(
        .PSC_W (4),
        .PINS  (6)
    ) uPsc (
        .clock        (clock),
        .rst          (r.coreRst),
        .sysClkEn     (r.sysEn),
        .fastMode     (r.fast),
        .preSel       (r.preSel),
        .twoBypass    (timerTwoClockOutMode | timerTwoBaudMode),
        .pinIn        ({externalInterruptOne, externalInterruptZero,
                        timerTwoExternalTrigger, timerTwoInput,
                        timerOneInput, timerZeroInput}),
        .timerTick    (timerTick),
        .timerTwoTick (timerTwoTick),
        .pinSampled   (smpPins)
    );

    // Outputs
    assign dat_o       = r.dat;
    assign ack_o       = r.ack;
    assign coreReset   = r.coreRst;
    assign fastMode    = r.fast;
    assign sysClkEn    = r.sysEn;
    assign fetchEn     = r.fetchEn;
    assign instrDone   = r.insDone;
    assign sampledPins = smpPins;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (anyRst);

    sequence seqNoFetch2;
        !r.fetchEn [*2];
    endsequence

    AST_FETCH_FAST: assert property (r.fast && r.sysEn |=> r.fetchEn) // [RL1]
        else $error("fast mode fetch missing");
    AST_FETCH_SLOW: assert property (!r.fast && r.fetchEn |=> seqNoFetch2) // [RL1]
        else $error("compat mode fetch too soon");
    AST_INS_LEN: assert property (r.insDone |-> r.insCnt == r.insTgt && // [RL2]
        (r.fast ? r.insTgt <= 5'h05
                : r.insTgt inside {5'h06, 5'h0C, 5'h12, 5'h18}))
        else $error("instruction length out of range");
    AST_MODE_SET: assert property ($past(anyRst) |-> // [RL3]
        r.fast == !$past(compatFuseEn))
        else $error("mode not taken from fuse");
    AST_MODE_HOLD: assert property (!$past(anyRst) |-> $stable(r.fast)) // [RL16]
        else $error("mode changed outside reset");
    AST_DIV_DEF: assert property ($past(anyRst) |-> // [RL4]
        r.div == DIV_W'(emtc_pkg::DIV_RST) && r.undiv == (r.fast | $past(undivFuseEn)))
        else $error("divider default wrong");
    AST_PSEL_DEF: assert property ($past(anyRst) |-> r.preSel == // [RL9]
        (r.fast ? emtc_pkg::PSEL_RST_FAST : emtc_pkg::PSEL_RST_COMPAT))
        else $error("prescaler default wrong");
    AST_X1_GAP: assert property (!r.undiv && r.sysEn |=> !r.sysEn) // [RL5]
        else $error("divide by two missing");
    AST_RST_POL: assert property (@(posedge clock) disable iff (1'b0) // [RL12]
        resetPolaritySelect == resetPin |=> r.coreRst)
        else $error("reset pin polarity ignored");
    AST_POR: assert property (@(posedge clock) disable iff (1'b0) // [RL14]
        rst |=> r.coreRst)
        else $error("power-on reset ignored");
endmodule

/* dv/emtc_board.sv */
`timescale 1ns/1ps
module emtc_board (
    // Clock and strap
    input  wire logic       clock,
    input  wire logic       rstPolarity,
    // Lines into the device
    output logic            resetPin,
    output logic [5:0]      pinLevel
);
    logic holdRst = 1'b0;
    // Released pin rests at its pull level
    assign resetPin = holdRst ? rstPolarity : !rstPolarity;
    initial pinLevel = 6'h00;
    // Reset pulse of n clocks; caller scales system clocks by the divider
    task automatic pulse(input int n);
        @(posedge clock);
        holdRst <= 1'b1;
        repeat (n) @(posedge clock);
        holdRst <= 1'b0;
    endtask
    // Timer and interrupt pins change just after an edge
    task automatic drive(input logic [5:0] v);
        @(posedge clock);
        pinLevel <= v;
    endtask
endmodule

/* dv/execution_mode_timing_control_test.sv */
`timescale 1ns/1ps
module execution_mode_timing_control_test;
    logic        clock = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] datW = 32'h0, datR, q;
    logic        ack, comp = 1'b0, x2f = 1'b0, oscf = 1'b0, rstPolarity = 1'b1;
    logic [1:0]  srcA = 2'h0, srcB = 2'h0;
    logic [2:0]  tickA = 3'h7, tickB = 3'h0, iLen = 3'h1;
    logic        iStart = 1'b0, t2c = 1'b0, t2b = 1'b0, resetPin;
    logic [5:0]  pins, sampledPins;
    logic        coreReset, fastMode, sysClkEn, fetchEn, instrDone, timerTick, timerTwoTick;
    int          error_cnt = 0, check_count = 0, cS, cF, cT, c2, t1, tk;

    always #5 clock = ~clock;

    emtc_board brd (.clock(clock), .rstPolarity(rstPolarity), .resetPin(resetPin),
        .pinLevel(pins));

    emtc_top dut (.clock(clock), .rst(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we),
        .adr_i(adr), .sel_i(4'hF), .dat_i(datW), .dat_o(datR), .ack_o(ack),
        .compatFuseEn(comp), .undivFuseEn(x2f), .oscSelFuse(oscf), .srcAFuse(srcA),
        .srcBFuse(srcB), .resetPin(resetPin), .resetPolaritySelect(rstPolarity),
        .oscATick(tickA), .oscBTick(tickB), .instrStart(iStart), .instrLen(iLen),
        .timerTwoClockOutMode(t2c), .timerTwoBaudMode(t2b), .timerZeroInput(pins[0]),
        .timerOneInput(pins[1]), .timerTwoInput(pins[2]),
        .timerTwoExternalTrigger(pins[3]), .externalInterruptZero(pins[4]),
        .externalInterruptOne(pins[5]), .coreReset(coreReset), .fastMode(fastMode),
        .sysClkEn(sysClkEn), .fetchEn(fetchEn), .instrDone(instrDone),
        .timerTick(timerTick), .timerTwoTick(timerTwoTick), .sampledPins(sampledPins));

    // Compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: %s", $time, m);
        end
    endtask

    // Classic Wishbone single cycle
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        datW <= d;
        do begin
            @(posedge clock);
            n++;
        end while (ack !== 1'b1 && n < 50);
        q = datR;
        if (n >= 50) chk(1'b0, 1'b1, "bus timeout");
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    // Fuse setup and power-on reset
    task automatic boot(input logic c, input logic x, input logic o, input logic [1:0] a,
                        input logic [1:0] b);
        @(posedge clock);
        comp <= c;
        x2f <= x;
        oscf <= o;
        srcA <= a;
        srcB <= b;
        rst <= 1'b1;
        repeat (5) @(posedge clock);
        @(negedge clock);
        chk(coreReset, 1'b1, "power-on reset");
        @(posedge clock);
        rst <= 1'b0;
        repeat (4) @(posedge clock);
    endtask

    // Pulse counts over a window
    task automatic tally(input int n);
        cS = 0;
        cF = 0;
        cT = 0;
        c2 = 0;
        repeat (4) @(posedge clock);
        repeat (n) begin
            @(negedge clock);
            cS += int'(sysClkEn === 1'b1);
            cF += int'(fetchEn === 1'b1);
            cT += int'(timerTick === 1'b1);
            c2 += int'(timerTwoTick === 1'b1);
        end
    endtask

    // Cycles from start to instruction end
    task automatic ilen(input logic [2:0] k, output int t);
        @(posedge clock);
        iStart <= 1'b1;
        iLen <= k;
        @(posedge clock);
        iStart <= 1'b0;
        t = 0;
        while (instrDone !== 1'b1 && t < 300) begin
            @(negedge clock);
            t++;
        end
    endtask

    task automatic s_fast;
        boot(1'b0, 1'b0, 1'b0, 2'h0, 2'h0);
        chk(fastMode, 1'b1, "fast mode");
        wb(1'b0, emtc_pkg::ADR_CFG, 32'h0);
        chk(q, 32'h01, "fast cfg");
        tally(60);
        chk(cS, 60, "fast sysclk");
        chk(cF, 60, "fast fetch");
        chk(cT, 60, "fast prescale");
        ilen(3'h1, t1);
        for (int k = 2; k <= 5; k++) begin
            ilen(3'(k), tk);
            chk(tk - t1, k - 1, "fast length");
        end
        brd.drive(6'h2A);
        repeat (3) @(negedge clock);
        chk(sampledPins, 6'h2A, "fast sampling");
        wb(1'b1, emtc_pkg::ADR_CFG, 32'h31);
        tally(60);
        chk(cT, 15, "prescale 4");
        wb(1'b1, emtc_pkg::ADR_CFG, 32'hF1);
        tally(48);
        chk(cT, 3, "prescale 16");
        chk(c2, 3, "timer two plain");
        @(posedge clock);
        t2c <= 1'b1;
        tally(48);
        chk(c2, 48, "clock-out bypass");
        @(posedge clock);
        t2c <= 1'b0;
        t2b <= 1'b1;
        tally(48);
        chk(c2, 48, "baud bypass");
        @(posedge clock);
        t2b <= 1'b0;
        wb(1'b0, 8'h0C, 32'h0);
        chk(q, 32'h0, "unmapped read");
        comp <= 1'b1;
        wb(1'b0, emtc_pkg::ADR_STAT, 32'h0);
        chk(q & 32'h3F07, 32'h2A01, "stat held");
        brd.pulse(2);
        @(negedge clock);
        chk(coreReset, 1'b1, "high reset pin");
        wb(1'b0, emtc_pkg::ADR_CFG, 32'h0);
        chk(q, 32'h50, "cfg restored");
        rstPolarity <= 1'b0;
        repeat (4) @(negedge clock);
        chk(coreReset, 1'b0, "idle low polarity");
        // Compat mode divides by two: 12 system clocks are 24 clocks
        brd.pulse(24);
        @(negedge clock);
        chk(coreReset, 1'b1, "low reset pin");
        @(posedge clock);
        rstPolarity <= 1'b1;
    endtask

    task automatic s_compat;
        boot(1'b1, 1'b0, 1'b0, 2'h0, 2'h0);
        chk(fastMode, 1'b0, "compat mode");
        wb(1'b0, emtc_pkg::ADR_CFG, 32'h0);
        chk(q, 32'h50, "compat cfg");
        tally(60);
        chk(cS, 30, "compat sysclk");
        chk(cF, 10, "compat fetch");
        chk(cT, 5, "compat prescale");
        for (int n = 0; n < 30 && timerTick !== 1'b1; n++) @(negedge clock);
        brd.drive(6'h15);
        repeat (6) @(negedge clock);
        chk(sampledPins, 6'h2A, "held between ticks");
        repeat (14) @(negedge clock);
        chk(sampledPins, 6'h15, "sampled at tick");
        // First run aligns the start to the system clock phase
        ilen(3'h1, t1);
        ilen(3'h1, t1);
        for (int k = 2; k <= 4; k++) begin
            ilen(3'(k), tk);
            chk(tk - t1, (k - 1) * 12, "compat length");
        end
        wb(1'b1, emtc_pkg::ADR_CFG, 32'h51);
        tally(60);
        chk(cS, 60, "undivided");
        wb(1'b1, emtc_pkg::ADR_DIV, 32'h03);
        tally(60);
        chk(cS, 20, "divide 3");
    endtask

    task automatic s_source;
        @(posedge clock);
        tickA <= 3'h4;
        boot(1'b0, 1'b0, 1'b0, emtc_pkg::SRC_RC, 2'h0);
        wb(1'b0, emtc_pkg::ADR_STAT, 32'h0);
        chk(q & 32'h7, 32'h5, "rc source");
        tally(60);
        chk(cS, 60, "rc ticks");
        @(posedge clock);
        tickA <= 3'h1;
        tally(60);
        chk(cS, 0, "crystal ignored");
        @(posedge clock);
        tickA <= 3'h0;
        tickB <= 3'h2;
        boot(1'b0, 1'b0, 1'b1, 2'h0, emtc_pkg::SRC_EXT);
        wb(1'b0, emtc_pkg::ADR_STAT, 32'h0);
        chk(q & 32'h7, 32'h3, "second source");
        wb(1'b1, emtc_pkg::ADR_DIV, 32'h02);
        tally(60);
        chk(cS, 30, "second divided");
        wb(1'b1, emtc_pkg::ADR_CFG, 32'h02);
        tally(60);
        chk(cS, 15, "second halved");
    endtask

    task automatic conclude;
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        s_fast;
        s_compat;
        s_source;
        conclude;
    end

    // Hang guard
    initial begin
        #200000;
        error_cnt++;
        conclude;
    end
endmodule
